/* File: design/dcbr_defs.svh */
// Constants for the dual-clock block RAM tile: register map, fields, geometry.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef DCBR_DEFS_SVH
`define DCBR_DEFS_SVH

// ==========================================================================
// Geometry
`define DCBR_ROWS 256
`define DCBR_ROW_W 8
`define DCBR_WORD_W 16
`define DCBR_ADDR_W 11

// ==========================================================================
// Register map (byte addresses)
`define DCBR_AV_ADDR_W 4
`define DCBR_OFF_CTRL 4'h0
`define DCBR_OFF_PL_ADDR 4'h4
`define DCBR_OFF_PL_DATA 4'h8
`define DCBR_OFF_STATUS 4'hC

// ==========================================================================
// Control and status fields and reset values
`define DCBR_CTRL_RATIO 1:0
`define DCBR_CTRL_EDGE 3:2
`define DCBR_CTRL_RUN 4
`define DCBR_RST_RATIO 2'h0
`define DCBR_RST_EDGE 2'h0
`define DCBR_RST_RUN 1'h0
`define DCBR_STAT_RUN 0
`define DCBR_STAT_WPEND 1
`define DCBR_STAT_RPEND 2

`endif

/* File: design/dcbr_pkg.sv */
// Types shared by the block RAM tile files.
// Assumes dcbr_defs.svh is on the include path.
`include "dcbr_defs.svh"

package dcbr_pkg;

    // ======================================================================
    // Modes
    typedef enum logic [1:0]
    {
        DCBR_R256X16 = 2'h0,
        DCBR_R512X8 = 2'h1,
        DCBR_R1024X4 = 2'h2,
        DCBR_R2048X2 = 2'h3
    } dcbr_ratio_t;

    // Bit 0 set: read port on falling edges; bit 1 set: write port likewise
    typedef enum logic [1:0]
    {
        DCBR_EDGE_RISE = 2'h0,
        DCBR_EDGE_FALL_READ = 2'h1,
        DCBR_EDGE_FALL_WRITE = 2'h2,
        DCBR_EDGE_FALL_BOTH = 2'h3
    } dcbr_edge_t;

    // ======================================================================
    // Port bundles
    typedef struct packed {
        logic clk;
        logic clk_gate;
        logic en;
        logic [`DCBR_ADDR_W-1:0] addr;
        logic [`DCBR_WORD_W-1:0] data;
        logic [`DCBR_WORD_W-1:0] mask;
    } dcbr_wr_pins_t;

    typedef struct packed {
        logic clk;
        logic clk_gate;
        logic en;
        logic [`DCBR_ADDR_W-1:0] addr;
    } dcbr_rd_pins_t;

endpackage

/* File: design/dcbr_sync.sv */
// Two-stage synchroniser for a bundle of pins.
// Assumes the bundle is held stable around its own clock edge.
`timescale 1ns/1ps

module dcbr_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } dcbr_sync_st_t;

    dcbr_sync_st_t st_r;
    dcbr_sync_st_t st_nxt;

    always_comb
    begin
        st_nxt.s1 = i_d;
        st_nxt.s2 = st_r.s1;
        if (i_rst)
        begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        st_r <= st_nxt;
    end

    assign o_q = st_r.s2;

endmodule

/* File: design/dcbr_top.sv */
// Dual-port 4 kbit block RAM tile with register access over Avalon-MM.
// Assumes fabric port clocks well below i_clk/4; pins are synchronised here.
`timescale 1ns/1ps
`include "dcbr_defs.svh"

module dcbr_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Avalon-MM slave
    input wire logic [`DCBR_AV_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Write port
    input wire logic i_wr_clk,
    input wire logic i_wr_clk_gate,
    input wire logic i_wr_enable,
    input wire logic [`DCBR_ADDR_W-1:0] i_wr_addr,
    input wire logic [`DCBR_WORD_W-1:0] i_wr_data,
    input wire logic [`DCBR_WORD_W-1:0] i_wr_mask,
    // Read port
    input wire logic i_rd_clk,
    input wire logic i_rd_clk_gate,
    input wire logic i_rd_enable,
    input wire logic [`DCBR_ADDR_W-1:0] i_rd_addr,
    output logic [`DCBR_WORD_W-1:0] o_rd_data
);

    // ======================================================================
    // State
    typedef struct packed {
        dcbr_pkg::dcbr_ratio_t ratio;
        dcbr_pkg::dcbr_edge_t edge_sel;
        logic run;
        logic [`DCBR_ROW_W-1:0] pl_addr;
        logic [31:0] rdata;
        logic ack;
        logic wclk_d;
        logic rclk_d;
        logic wpend;
        logic [`DCBR_ADDR_W-1:0] wa;
        logic [`DCBR_WORD_W-1:0] wd;
        logic [`DCBR_WORD_W-1:0] wm;
        logic rpend;
        logic [`DCBR_ADDR_W-1:0] ra;
        logic [`DCBR_WORD_W-1:0] rd_data;
        logic [`DCBR_ROWS-1:0][`DCBR_WORD_W-1:0] mem;
    } dcbr_state_t;

    dcbr_state_t st_r;
    dcbr_state_t st_nxt;
    dcbr_pkg::dcbr_wr_pins_t wr_pins;
    dcbr_pkg::dcbr_wr_pins_t wr_s;
    dcbr_pkg::dcbr_rd_pins_t rd_pins;
    dcbr_pkg::dcbr_rd_pins_t rd_s;

    // ======================================================================
    // Pin synchronisers; clock and data take the same delay so they stay aligned
    assign wr_pins = '{clk: i_wr_clk, clk_gate: i_wr_clk_gate, en: i_wr_enable,
                       addr: i_wr_addr, data: i_wr_data, mask: i_wr_mask};
    assign rd_pins = '{clk: i_rd_clk, clk_gate: i_rd_clk_gate, en: i_rd_enable,
                       addr: i_rd_addr};

    dcbr_sync #(.W($bits(dcbr_pkg::dcbr_wr_pins_t))) u_wr_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_d(wr_pins),
        .o_q(wr_s)
    );

    dcbr_sync #(.W($bits(dcbr_pkg::dcbr_rd_pins_t))) u_rd_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_d(rd_pins),
        .o_q(rd_s)
    );

    // ======================================================================
    // Geometry helpers
    function automatic logic [`DCBR_ROW_W-1:0] f_row(
        input logic [`DCBR_ADDR_W-1:0] a,
        input dcbr_pkg::dcbr_ratio_t r
    );
        logic [`DCBR_ADDR_W-1:0] t;
        t = a >> r;
        return t[`DCBR_ROW_W-1:0];
    endfunction

    // Bits of the row that a narrow write may touch
    function automatic logic [`DCBR_WORD_W-1:0] f_lane(
        input logic [`DCBR_ADDR_W-1:0] a,
        input dcbr_pkg::dcbr_ratio_t r,
        input logic [`DCBR_WORD_W-1:0] m
    );
        unique case (r)
            dcbr_pkg::DCBR_R256X16: return ~m;
            dcbr_pkg::DCBR_R512X8: return a[0] ? 16'hFF00 : 16'h00FF;
            dcbr_pkg::DCBR_R1024X4: return 16'h000F << {a[1:0], 2'h0};
            dcbr_pkg::DCBR_R2048X2: return 16'h0003 << {a[2:0], 1'h0};
        endcase
    endfunction

    function automatic logic [`DCBR_WORD_W-1:0] f_rep(
        input logic [`DCBR_WORD_W-1:0] d,
        input dcbr_pkg::dcbr_ratio_t r
    );
        unique case (r)
            dcbr_pkg::DCBR_R256X16: return d;
            dcbr_pkg::DCBR_R512X8: return {2{d[7:0]}};
            dcbr_pkg::DCBR_R1024X4: return {4{d[3:0]}};
            dcbr_pkg::DCBR_R2048X2: return {8{d[1:0]}};
        endcase
    endfunction

    // Narrow read data sits in the low bits, upper bits read zero
    function automatic logic [`DCBR_WORD_W-1:0] f_pick(
        input logic [`DCBR_WORD_W-1:0] w,
        input logic [`DCBR_ADDR_W-1:0] a,
        input dcbr_pkg::dcbr_ratio_t r
    );
        logic [`DCBR_WORD_W-1:0] t;
        t = '0;
        unique case (r)
            dcbr_pkg::DCBR_R256X16: t = w;
            dcbr_pkg::DCBR_R512X8:
            begin
                t = w >> {a[0], 3'h0};
                t = {8'h00, t[7:0]};
            end
            dcbr_pkg::DCBR_R1024X4:
            begin
                t = w >> {a[1:0], 2'h0};
                t = {12'h000, t[3:0]};
            end
            dcbr_pkg::DCBR_R2048X2:
            begin
                t = w >> {a[2:0], 1'h0};
                t = {14'h0000, t[1:0]};
            end
        endcase
        return t;
    endfunction

    // ======================================================================
    // Next state
    always_comb
    begin
        logic wr_edge;
        logic rd_edge;
        logic [`DCBR_ROW_W-1:0] wrow;
        logic [`DCBR_WORD_W-1:0] bm;
        logic [`DCBR_WORD_W-1:0] cur;
        logic [31:0] rb;
        wr_edge = 1'h0;
        rb = '0;
        rd_edge = 1'h0;
        wrow = '0;
        bm = '0;
        cur = '0;
        st_nxt = st_r;
        st_nxt.wclk_d = wr_s.clk;
        st_nxt.rclk_d = rd_s.clk;

        // Active edge per port follows the chosen variant
        wr_edge = st_r.edge_sel[1] ? (st_r.wclk_d & ~wr_s.clk)
                                   : (~st_r.wclk_d & wr_s.clk);
        rd_edge = st_r.edge_sel[0] ? (st_r.rclk_d & ~rd_s.clk)
                                   : (~st_r.rclk_d & rd_s.clk);

        // Input registers, then the array one cycle later
        st_nxt.wpend = 1'h0;
        if (wr_edge && wr_s.clk_gate && wr_s.en && st_r.run)
        begin
            st_nxt.wpend = 1'h1;
            st_nxt.wa = wr_s.addr;
            st_nxt.wd = wr_s.data;
            st_nxt.wm = wr_s.mask;
        end
        if (st_r.wpend)
        begin
            wrow = f_row(st_r.wa, st_r.ratio);
            bm = f_lane(st_r.wa, st_r.ratio, st_r.wm);
            st_nxt.mem[wrow] = (st_r.mem[wrow] & ~bm) | (f_rep(st_r.wd, st_r.ratio) & bm);
        end

        st_nxt.rpend = 1'h0;
        if (rd_edge && rd_s.clk_gate && rd_s.en && st_r.run)
        begin
            st_nxt.rpend = 1'h1;
            st_nxt.ra = rd_s.addr;
        end
        if (st_r.rpend)
        begin
            cur = st_r.mem[f_row(st_r.ra, st_r.ratio)];
            st_nxt.rd_data = f_pick(cur, st_r.ra, st_r.ratio);
        end

        // Register access: read data loads on the first edge of a request, while waitrequest is high; a write lands
        // only on the edge at which the master sees waitrequest low
        st_nxt.ack = 1'h0;
        if (i_avs_read || i_avs_write)
        begin
            st_nxt.ack = !st_r.ack;
            unique case (i_avs_address)
                `DCBR_OFF_CTRL:
                begin
                    rb[`DCBR_CTRL_RATIO] = st_r.ratio;
                    rb[`DCBR_CTRL_EDGE] = st_r.edge_sel;
                    rb[`DCBR_CTRL_RUN] = st_r.run;
                    if (i_avs_write && st_r.ack)
                    begin
                        st_nxt.ratio = dcbr_pkg::dcbr_ratio_t'(i_avs_writedata[`DCBR_CTRL_RATIO]);
                        st_nxt.edge_sel = dcbr_pkg::dcbr_edge_t'(i_avs_writedata[`DCBR_CTRL_EDGE]);
                        st_nxt.run = i_avs_writedata[`DCBR_CTRL_RUN];
                    end
                end
                `DCBR_OFF_PL_ADDR:
                begin
                    rb[`DCBR_ROW_W-1:0] = st_r.pl_addr;
                    if (i_avs_write && st_r.ack)
                    begin
                        st_nxt.pl_addr = i_avs_writedata[`DCBR_ROW_W-1:0];
                    end
                end
                `DCBR_OFF_PL_DATA:
                begin
                    rb[`DCBR_WORD_W-1:0] = st_r.mem[st_r.pl_addr];
                    // Preload only while user ports are held off
                    if (i_avs_write && st_r.ack && !st_r.run)
                    begin
                        st_nxt.mem[st_r.pl_addr] = i_avs_writedata[`DCBR_WORD_W-1:0];
                        st_nxt.pl_addr = st_r.pl_addr + 8'h01;
                    end
                end
                `DCBR_OFF_STATUS:
                begin
                    rb[`DCBR_STAT_RUN] = st_r.run;
                    rb[`DCBR_STAT_WPEND] = st_r.wpend;
                    rb[`DCBR_STAT_RPEND] = st_r.rpend;
                end
                default:
                begin
                    rb = '0;
                end
            endcase
            st_nxt.rdata = st_r.ack ? st_r.rdata : rb;
        end

        // Contents survive reset so a preload is kept
        if (i_rst)
        begin
            st_nxt.ratio = dcbr_pkg::dcbr_ratio_t'(`DCBR_RST_RATIO);
            st_nxt.edge_sel = dcbr_pkg::dcbr_edge_t'(`DCBR_RST_EDGE);
            st_nxt.run = `DCBR_RST_RUN;
            st_nxt.pl_addr = '0;
            st_nxt.rdata = '0;
            st_nxt.ack = 1'h0;
            st_nxt.wclk_d = 1'h0;
            st_nxt.rclk_d = 1'h0;
            st_nxt.wpend = 1'h0;
            st_nxt.wa = '0;
            st_nxt.wd = '0;
            st_nxt.wm = '0;
            st_nxt.rpend = 1'h0;
            st_nxt.ra = '0;
            st_nxt.rd_data = '0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        st_r <= st_nxt;
    end

    // ======================================================================
    // Outputs
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !st_r.ack;
    assign o_avs_readdata = st_r.rdata;
    assign o_rd_data = st_r.rd_data;

endmodule

/* File: sim/dcbr_top_checker.sv */
// Assertions on the tile's Avalon slave and read port.
// Bound onto dcbr_top; sees its ports only.
`timescale 1ns/1ps

module dcbr_top_checker (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Avalon-MM
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // Read port
    input wire logic i_rd_clk_gate,
    input wire logic i_rd_enable,
    input wire logic [15:0] o_rd_data
);
    // ====================
    // Shadow of CTRL, cycles since the read port was enabled
    logic [4:0] ctrl_r;
    logic [3:0] quiet_r;
    wire logic req = i_avs_read || i_avs_write;
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ctrl_r <= 5'h00;
            quiet_r <= 4'hF;
        end
        else
        begin
            if (i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h0)
                ctrl_r <= i_avs_writedata[4:0];
            quiet_r <= (i_rd_enable && i_rd_clk_gate) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hF};
        end
    end
    // ====================
    // Properties
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    sequence s_start;
        $rose(i_avs_read) || $rose(i_avs_write);
    endsequence
    sequence s_one_wait;
        o_avs_waitrequest ##1 !o_avs_waitrequest;
    endsequence
    sequence s_rd_done;
        i_avs_read && !o_avs_waitrequest;
    endsequence
    AST_AV_ONE_WAIT: assert property (s_start |-> s_one_wait)
        else $error("access did not take one wait state");
    AST_AV_IDLE: assert property (!req |-> !o_avs_waitrequest)
        else $error("waitrequest high without request");
    AST_AV_HOLE: assert property (s_rd_done ##0 (i_avs_address[1:0] != 2'h0)
        |-> o_avs_readdata == 32'h0) else $error("unmapped read not zero");
    AST_AV_STANDS: assert property (!req |=> $stable(o_avs_readdata))
        else $error("readdata moved while idle");
    AST_CTRL_BACK: assert property (s_rd_done ##0 (i_avs_address == 4'h0)
        |-> o_avs_readdata[4:0] == ctrl_r) else $error("control readback wrong");
    AST_STAT_RUN: assert property (s_rd_done ##0 (i_avs_address == 4'hC)
        |-> o_avs_readdata[0] == ctrl_r[4]) else $error("status run bit wrong");
    AST_RD_HOLD: assert property ($changed(o_rd_data) |-> quiet_r < 4'h8)
        else $error("read data moved without enabled read");
    AST_RD_STOPPED: assert property (!ctrl_r[4] |=> $stable(o_rd_data))
        else $error("read data moved while stopped");
    AST_RD_NARROW: assert property ($changed(o_rd_data) && ctrl_r[1:0] != 2'h0
        |-> (o_rd_data >> (16 >> ctrl_r[1:0])) == 16'h0) else $error("narrow upper bits set");
endmodule

bind dcbr_top dcbr_top_checker u_chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_rd_clk_gate(i_rd_clk_gate),
    .i_rd_enable(i_rd_enable), .o_rd_data(o_rd_data));

/* File: sim/dcbr_fabric.sv */
// Fabric user logic model driving the tile's write and read pins.
// Assumes i_clk is the system clock; port clocks stand low between operations.
`timescale 1ns/1ps

module dcbr_fabric (
    // Clock
    input wire logic i_clk,
    // Port pins
    output dcbr_pkg::dcbr_wr_pins_t o_wr,
    output dcbr_pkg::dcbr_rd_pins_t o_rd
);
    initial o_wr = '0;
    initial o_rd = '0;
    // ====================
    // One port clock cycle: a0/d0 stand at the rise, a1/d1 at the fall
    task automatic put(input logic w, c, g, e, input logic [10:0] a, input logic [15:0] d, m);
        if (w)
            o_wr <= '{c, g, e, a, d, m};
        else
            o_rd <= '{c, g, e, a};
    endtask
    task automatic op(input logic w, g, e, input logic [10:0] a0, a1, input logic [15:0] d0, d1, m);
        @(posedge i_clk);
        put(w, 1'b0, g, e, a0, d0, m);
        repeat (5) @(posedge i_clk);
        put(w, 1'b1, g, e, a0, d0, m);
        repeat (5) @(posedge i_clk);
        put(w, 1'b1, g, e, a1, d1, m);
        repeat (5) @(posedge i_clk);
        put(w, 1'b0, g, e, a1, d1, m);
        repeat (7) @(posedge i_clk);
        // Released lines flip so a stale value cannot pass
        put(w, 1'b0, 1'b0, 1'b0, ~a1, ~d1, ~m);
    endtask
endmodule

/* File: sim/dcbr_top_test.sv */
// Self-checking bench: Avalon setup and preload, then fabric traffic.
// Assumes dcbr_fabric drives the port pins and the checker is bound in.
`timescale 1ns/1ps
`include "dcbr_defs.svh"

module dcbr_top_test;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [3:0] av_addr = '0;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [31:0] av_wdata = '0;
    logic [31:0] av_rdata, q;
    logic av_wait;
    logic [15:0] rd_data, d0, m;
    logic [10:0] a0, a1, wa, b0;
    dcbr_pkg::dcbr_wr_pins_t wp;
    dcbr_pkg::dcbr_rd_pins_t rp;
    logic [15:0] mem [256];
    int n_fail = 0;
    int n_tests = 0;
    int seed = 32'h74C18A1D;
    always #2 i_clk = ~i_clk;
    dcbr_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(av_addr),
        .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wdata),
        .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait), .i_wr_clk(wp.clk),
        .i_wr_clk_gate(wp.clk_gate), .i_wr_enable(wp.en), .i_wr_addr(wp.addr),
        .i_wr_data(wp.data), .i_wr_mask(wp.mask), .i_rd_clk(rp.clk),
        .i_rd_clk_gate(rp.clk_gate), .i_rd_enable(rp.en), .i_rd_addr(rp.addr),
        .o_rd_data(rd_data));
    dcbr_fabric fab (.i_clk(i_clk), .o_wr(wp), .o_rd(rp));
    // ====================
    // Expectations and checks
    function automatic logic [15:0] exp_rd(input logic [10:0] a, input logic [1:0] k);
        int w = 16 >> k;
        int l = int'(a) & ((1 << k) - 1);
        return 16'((mem[8'(a >> k)] >> (l * w)) & ((1 << w) - 1));
    endfunction
    task automatic mdl_wr(input logic [10:0] a, input logic [1:0] k, input logic [15:0] d, m);
        int w = 16 >> k;
        int l = int'(a) & ((1 << k) - 1);
        logic [15:0] lm = (k == 2'h0) ? ~m : 16'(((1 << w) - 1) << (l * w));
        mem[8'(a >> k)] = (mem[8'(a >> k)] & ~lm) | (16'(d << (l * w)) & lm);
    endtask
    task automatic chk_reg(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t register %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rd(input logic [15:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t read port %h expected %h", $time, got, exp);
        end
    endtask
    // Request holds until waitrequest is seen low at a rising edge
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        av_addr <= a;
        av_wdata <= d;
        av_wr <= w;
        av_rd <= !w;
        do
            @(posedge i_clk);
        while (av_wait !== 1'b0);
        q = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask
    task automatic peek(input logic [7:0] r);
        av(1'b1, `DCBR_OFF_PL_ADDR, {24'h0, r});
        av(1'b0, `DCBR_OFF_PL_DATA, 32'h0);
        chk_reg({16'h0, q[15:0]}, {16'h0, mem[r]});
    endtask
    task automatic wr(input logic g, e, input logic [10:0] x, y, input logic [15:0] d, e2, k);
        fab.op(1'b1, g, e, x, y, d, e2, k);
    endtask
    task automatic rd(input logic g, e, input logic [10:0] x, y);
        fab.op(1'b0, g, e, x, y, 16'h0, 16'h0, 16'h0);
    endtask
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ====================
    // Sequence
    initial
    begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        av(1'b0, `DCBR_OFF_STATUS, 32'h0);
        chk_reg(q, 32'h0);
        av(1'b0, 4'h6, 32'h0);
        chk_reg(q, 32'h0);
        av(1'b1, `DCBR_OFF_PL_ADDR, 32'h0);
        for (int i = 0; i < 256; i++)
        begin
            mem[i] = 16'($random(seed));
            av(1'b1, `DCBR_OFF_PL_DATA, {16'h0, mem[i]});
        end
        peek(8'h5A);
        rd(1'b1, 1'b1, 11'h005, 11'h005);
        chk_rd(rd_data, 16'h0);
        for (int v = 0; v < 16; v++)
        begin
            av(1'b1, `DCBR_OFF_CTRL, {27'h0, 1'b1, v[3:2], v[1:0]});
            av(1'b0, `DCBR_OFF_CTRL, 32'h0);
            chk_reg(q, {27'h0, 1'b1, v[3:0]});
            a0 = 11'($random(seed)) & 11'((1 << (8 + v[1:0])) - 1);
            a1 = a0 ^ 11'h001;
            d0 = 16'($random(seed));
            m = (v[1:0] == 2'h0) ? 16'($random(seed)) : 16'hFFFF;
            rd(1'b1, 1'b1, a0, a0);
            chk_rd(rd_data, exp_rd(a0, v[1:0]));
            wa = v[3] ? a1 : a0;
            mdl_wr(wa, v[1:0], v[3] ? ~d0 : d0, m);
            wr(1'b1, 1'b1, a0, a1, d0, ~d0, m);
            b0 = wa ^ 11'h002;
            rd(1'b1, 1'b1, v[2] ? b0 : wa, v[2] ? wa : b0);
            chk_rd(rd_data, exp_rd(wa, v[1:0]));
        end
        av(1'b1, `DCBR_OFF_CTRL, 32'h10);
        av(1'b0, `DCBR_OFF_STATUS, 32'h0);
        chk_reg(q, 32'h1);
        for (int j = 0; j < 2; j++)
        begin
            a0 = 11'($random(seed)) & 11'h0FF;
            wr(j[0], !j[0], a0, a0, ~mem[a0[7:0]], ~mem[a0[7:0]], 16'h0);
            rd(1'b1, 1'b1, a0, a0);
            chk_rd(rd_data, mem[a0[7:0]]);
            rd(j[0], !j[0], a0 ^ 11'h001, a0 ^ 11'h001);
            chk_rd(rd_data, mem[a0[7:0]]);
        end
        d0 = 16'($random(seed));
        mdl_wr(11'h0A5, 2'h0, d0, 16'h0);
        fork
            wr(1'b1, 1'b1, 11'h0A5, 11'h0A5, d0, d0, 16'h0);
            rd(1'b1, 1'b1, 11'h05A, 11'h05A);
        join
        chk_rd(rd_data, mem[8'h5A]);
        rd(1'b1, 1'b1, 11'h0A5, 11'h0A5);
        chk_rd(rd_data, d0);
        av(1'b1, `DCBR_OFF_CTRL, 32'h0);
        wr(1'b1, 1'b1, 11'h0A5, 11'h0A5, ~d0, ~d0, 16'h0);
        peek(8'hA5);
        // Reset while stopped: control stays clear, contents are kept
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        av(1'b0, `DCBR_OFF_CTRL, 32'h0);
        chk_reg(q, 32'h0);
        peek(8'hA5);
        complete_run();
    end
    initial
    begin
        repeat (20000) @(posedge i_clk);
        n_fail++;
        $display("ERROR %0t watchdog expired", $time);
        complete_run();
    end
endmodule
